/* File: design/btg_guard.sv */
// Notes on behaviour
// - profile strap voltage windows select profiles one-six
// - strap outside all windows flags fault
// - profiles one, three: charge stop 0C/45C
// - profiles one, five: discharge stop -20C/60C
// - profile two: charge stop 2C/43C
// - profiles two, three: discharge stop -10C/55C
// - profiles four, six: discharge stop -20C/55C
// - profile four: stop below -10C, 0.2C to 0C
// - profile four: CV lowered 45-55C, stop above 55C
// - profile five: stop 2C/43C, 0.1C below 17C
// - profile six: 0.2C in both bands, stop outside
// - recovery needs 5C back inside threshold
// - source current on profile strap, read voltage
// - source current into thermistor, read voltage
// - die hot reduces power to stay below
// - power strap selects intelligent temperature option
// - capacity is single cell, 2000 to 30000 mAh
`timescale 1ns/100ps
`default_nettype none
module btg_guard
  import btg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned STEP_CYCLES   = THR_STEP_CYC
) (
  input  wire logic             REF_CLK_I,         // 200 MHz clock
  input  wire logic             RST_I,             // sync reset, active high
  input  wire logic             ADC_VALID_I,       // adc result strobe
  input  wire logic [1:0]       ADC_CHAN_I,        // adc channel of result
  input  wire logic [ADC_W-1:0] ADC_MV_I,          // adc result in mV
  input  wire logic             DIE_HOT_I,         // die temperature comparator
  output logic                  STRAP_ISRC_EN_O,   // strap current source enable
  output logic                  THERM_ISRC_EN_O,   // thermistor current source enable
  output logic                  READY_O,           // straps taken, guarding
  output logic [2:0]            PROFILE_O,         // selected profile 1..6, 0 none
  output logic                  PROFILE_FAULT_O,   // profile strap short/open
  output logic                  CHG_INHIBIT_O,     // stop charging
  output logic                  DSG_INHIBIT_O,     // stop discharging
  output logic                  CUR_LIMIT_EN_O,    // charge current limited
  output logic [15:0]           CUR_LIMIT_MA_O,    // charge current limit in mA
  output logic                  CV_DROP_EN_O,      // lower CV target 0.1V per cell
  output logic [2:0]            THROTTLE_LEVEL_O   // die power reduction level
);

  btg_state_type    state_q;
  logic [31:0]      settle_cnt_q;
  logic [2:0]       got_q;
  logic [2:0]       profile_q;
  logic [2:0]       option_q;
  logic [14:0]      cap_q;
  logic             therm_smp;
  logic             upd_q;
  logic [NUM_THR-1:0] trip;
  logic             die_meta_q;
  logic             die_hot_q;
  logic [31:0]      step_cnt_q;
  logic [2:0]       lvl_q;
  logic [2:0]       lvl_cap;
  logic             chg_stop;
  logic             dsg_stop;
  logic             lim_02;
  logic             lim_01;
  logic             cv_drop;
  logic [16:0]      cap_raw;
  logic [14:0]      cap_d;
  logic             strap_smp;

  function automatic logic [2:0] win_decode(input logic [ADC_W-1:0] mv);
    logic [2:0] code;
    code = PROFILE_NONE;
    if (mv >= WIN_LO_MV[0] && mv <= WIN_TOP_MV) begin
      for (int k = 0; k < 6; k++) begin
        if (mv >= WIN_LO_MV[k]) begin
          code = 3'(k + 1);
        end
      end
    end
    return code;
  endfunction : win_decode

  // strap sequencing: settle with source on, take each strap once
  assign strap_smp = (state_q == ST_SAMPLE) && ADC_VALID_I;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_q      <= ST_SETTLE;
      settle_cnt_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ST_SETTLE: begin
          if (settle_cnt_q == SETTLE_CYCLES - 1) begin
            state_q <= ST_SAMPLE;
          end else begin
            settle_cnt_q <= settle_cnt_q + 32'h0000_0001;
          end
        end
        ST_SAMPLE: begin
          if (got_q == 3'h7) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_SETTLE;
        end
      endcase
    end
  end

  assign STRAP_ISRC_EN_O = (state_q != ST_RUN);
  assign THERM_ISRC_EN_O = (state_q == ST_RUN);
  assign READY_O         = (state_q == ST_RUN);

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      got_q     <= 3'h0;
      profile_q <= PROFILE_NONE;
      option_q  <= PROFILE_NONE;
    end else if (strap_smp) begin
      // only the first result of each strap counts
      if (ADC_CHAN_I == CH_PROFILE && !got_q[0]) begin
        profile_q <= win_decode(ADC_MV_I);
        got_q[0]  <= 1'b1;
      end
      if (ADC_CHAN_I == CH_CAP && !got_q[1]) begin
        got_q[1] <= 1'b1;
      end
      if (ADC_CHAN_I == CH_PLIM && !got_q[2]) begin
        option_q <= win_decode(ADC_MV_I);
        got_q[2] <= 1'b1;
      end
    end
  end

  // capacity in mAh from the capacity strap, clamped to the cell range
  assign cap_raw = {5'h00, ADC_MV_I} * CAP_MUL;

  always_comb begin
    cap_d = cap_raw[15:1];
    if (ADC_MV_I < CAP_FAULT_LO_MV || ADC_MV_I > CAP_FAULT_HI_MV) begin
      // short or open strap: fall back to the default size
      cap_d = CAP_DEFAULT_MAH;
    end else if (cap_raw[16:1] < {1'b0, CAP_MIN_MAH}) begin
      cap_d = CAP_MIN_MAH;
    end else if (cap_raw[16:1] > {1'b0, CAP_MAX_MAH}) begin
      cap_d = CAP_MAX_MAH;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cap_q <= CAP_DEFAULT_MAH;
    end else if (strap_smp && ADC_CHAN_I == CH_CAP && !got_q[1]) begin
      cap_q <= cap_d;
    end
  end

  // thermistor comparators with recovery hysteresis
  // cold thresholds trip above the set point, hot ones below
  assign therm_smp = (state_q == ST_RUN) && ADC_VALID_I && (ADC_CHAN_I == CH_THERM);

  for (genvar i = 0; i < NUM_THR; i++) begin : g_thr
    btg_hyst_cmp #(
      .SET_MV (THR_SET_MV[i]),
      .REL_MV (THR_REL_MV[i]),
      .COLD   (i < NUM_COLD)
    ) u_cmp (
      .clk_i    (REF_CLK_I),
      .rst_i    (RST_I),
      .sample_i (therm_smp),
      .mv_i     (ADC_MV_I),
      .trip_o   (trip[i])
    );
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      upd_q <= 1'b0;
    end else begin
      // trips land on the strobe edge; outputs load one edge later
      upd_q <= therm_smp;
    end
  end

  // per-profile decisions from the comparator trips
  // trips carry the hysteresis, so each decision is plain logic on them
  always_comb begin
    chg_stop = 1'b1;
    dsg_stop = 1'b1;
    lim_02   = 1'b0;
    lim_01   = 1'b0;
    cv_drop  = 1'b0;
    unique case (profile_q)
      3'h1: begin
        chg_stop = trip[T_0] | trip[T_45];
        dsg_stop = trip[T_M20] | trip[T_60];
      end
      3'h2: begin
        chg_stop = trip[T_2] | trip[T_43];
        dsg_stop = trip[T_M10] | trip[T_55];
      end
      3'h3: begin
        chg_stop = trip[T_0] | trip[T_45];
        dsg_stop = trip[T_M10] | trip[T_55];
      end
      3'h4: begin
        chg_stop = trip[T_M10] | trip[T_55];
        lim_02   = trip[T_0] & ~chg_stop;
        cv_drop  = trip[T_45] & ~chg_stop;
        dsg_stop = trip[T_M20] | trip[T_55];
      end
      3'h5: begin
        chg_stop = trip[T_2] | trip[T_43];
        lim_01   = trip[T_17] & ~chg_stop;
        dsg_stop = trip[T_M20] | trip[T_60];
      end
      3'h6: begin
        chg_stop = trip[T_M10] | trip[T_55];
        lim_02   = (trip[T_0] | trip[T_45]) & ~chg_stop;
        dsg_stop = trip[T_M20] | trip[T_55];
      end
      default: begin
        chg_stop = 1'b1;
        dsg_stop = 1'b1;
      end
    endcase
  end

  // outputs move only on a fresh thermistor sample; inhibited until the first
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      CHG_INHIBIT_O  <= 1'b1;
      DSG_INHIBIT_O  <= 1'b1;
      CUR_LIMIT_EN_O <= 1'b0;
      CUR_LIMIT_MA_O <= 16'h0000;
      CV_DROP_EN_O   <= 1'b0;
    end else if (upd_q) begin
      CHG_INHIBIT_O  <= chg_stop;
      DSG_INHIBIT_O  <= dsg_stop;
      CUR_LIMIT_EN_O <= lim_02 | lim_01;
      CV_DROP_EN_O   <= cv_drop;
      if (lim_02) begin
        CUR_LIMIT_MA_O <= {1'b0, cap_q / DIV_0P2C};
      end else if (lim_01) begin
        CUR_LIMIT_MA_O <= {1'b0, cap_q / DIV_0P1C};
      end else begin
        CUR_LIMIT_MA_O <= 16'h0000;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      PROFILE_O       <= PROFILE_NONE;
      PROFILE_FAULT_O <= 1'b0;
    end else if (state_q == ST_RUN) begin
      // the strap result is final once guarding starts
      PROFILE_O       <= profile_q;
      PROFILE_FAULT_O <= (profile_q == PROFILE_NONE);
    end
  end

  // die temperature: comparator pin, two-stage synchroniser
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      die_meta_q <= 1'b0;
      die_hot_q  <= 1'b0;
    end else begin
      die_meta_q <= DIE_HOT_I;
      die_hot_q  <= die_meta_q;
    end
  end

  // option caps the reduction depth; no valid option allows full depth
  // one step per period gives the die time to respond before the next
  assign lvl_cap = (option_q == PROFILE_NONE) ? THR_LVL_MAX : option_q;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      step_cnt_q <= 32'h0000_0000;
      lvl_q      <= 3'h0;
    end else if (step_cnt_q == STEP_CYCLES - 1) begin
      step_cnt_q <= 32'h0000_0000;
      if (die_hot_q && lvl_q < lvl_cap) begin
        lvl_q <= lvl_q + 3'h1;
      end else if (!die_hot_q && lvl_q != 3'h0) begin
        lvl_q <= lvl_q - 3'h1;
      end
    end else begin
      step_cnt_q <= step_cnt_q + 32'h0000_0001;
    end
  end

  assign THROTTLE_LEVEL_O = lvl_q;

endmodule : btg_guard
`default_nettype wire

/* File: design/btg_pkg.sv */
package btg_pkg;

  localparam int unsigned ADC_W        = 12;
  localparam int unsigned CLK_FREQ_MHZ = 200;

  // strap settle after the source turns on, and die throttle step period
  localparam int unsigned SETTLE_TIME_US   = 1000;
  localparam int unsigned SETTLE_CYC       = SETTLE_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned THR_STEP_TIME_US = 10000;
  localparam int unsigned THR_STEP_CYC     = THR_STEP_TIME_US * CLK_FREQ_MHZ;

  // adc channel codes
  localparam logic [1:0] CH_THERM   = 2'h0;
  localparam logic [1:0] CH_PROFILE = 2'h1;
  localparam logic [1:0] CH_CAP     = 2'h2;
  localparam logic [1:0] CH_PLIM    = 2'h3;

  // strap windows in mV: lower bound of windows 1..6, upper bound of window 6
  localparam logic [ADC_W-1:0] WIN_LO_MV [6] = '{12'h0D8, 12'h17C, 12'h258,
                                                 12'h35C, 12'h4C4, 12'h6D6};
  localparam logic [ADC_W-1:0] WIN_TOP_MV     = 12'h9F6;
  localparam logic [2:0]       PROFILE_NONE   = 3'h0;

  // thermistor thresholds in mV, index:
  // 0:-20C 1:-10C 2:0C 3:2C 4:17C (cold side)  5:43C 6:45C 7:55C 8:60C (hot side)
  localparam int unsigned      NUM_THR  = 9;
  localparam int unsigned      NUM_COLD = 5;
  localparam logic [ADC_W-1:0] THR_SET_MV [NUM_THR] = '{12'h56E, 12'h35C, 12'h226,
    12'h1F4, 12'h1D6, 12'h1A4, 12'h186, 12'h118, 12'h0F0};
  // release points 5C back inside each threshold
  localparam logic [ADC_W-1:0] THR_REL_MV [NUM_THR] = '{12'h44C, 12'h2B2, 12'h1D6,
    12'h1B8, 12'h1AE, 12'h1E0, 12'h1C2, 12'h14A, 12'h118};
  localparam int unsigned T_M20 = 0;
  localparam int unsigned T_M10 = 1;
  localparam int unsigned T_0   = 2;
  localparam int unsigned T_2   = 3;
  localparam int unsigned T_17  = 4;
  localparam int unsigned T_43  = 5;
  localparam int unsigned T_45  = 6;
  localparam int unsigned T_55  = 7;
  localparam int unsigned T_60  = 8;

  // capacity strap: mAh = mV * 25 / 2, valid 100..2700 mV
  localparam logic [ADC_W-1:0] CAP_FAULT_LO_MV = 12'h064;
  localparam logic [ADC_W-1:0] CAP_FAULT_HI_MV = 12'hA8C;
  localparam logic [16:0]      CAP_MUL         = 17'h00019;
  localparam logic [14:0]      CAP_DEFAULT_MAH = 15'h1388;
  localparam logic [14:0]      CAP_MIN_MAH     = 15'h07D0;
  localparam logic [14:0]      CAP_MAX_MAH     = 15'h7530;
  localparam logic [14:0]      DIV_0P2C        = 15'h0005;
  localparam logic [14:0]      DIV_0P1C        = 15'h000A;

  localparam logic [2:0] THR_LVL_MAX = 3'h7;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_RUN    = 3'b100
  } btg_state_type;

endpackage : btg_pkg

/* File: design/btg_hyst_cmp.sv */
`timescale 1ns/100ps
`default_nettype none
module btg_hyst_cmp #(
  parameter logic [11:0] SET_MV = 12'h000,  // trip point
  parameter logic [11:0] REL_MV = 12'h000,  // release point
  parameter bit          COLD   = 1'b1      // trip when voltage above set point
) (
  input  wire logic        clk_i,     // clock
  input  wire logic        rst_i,     // sync reset
  input  wire logic        sample_i,  // new thermistor sample
  input  wire logic [11:0] mv_i,      // thermistor voltage
  output logic             trip_o     // threshold violated
);

  logic beyond_set;
  logic inside_rel;

  assign beyond_set = COLD ? (mv_i > SET_MV) : (mv_i < SET_MV);
  assign inside_rel = COLD ? (mv_i < REL_MV) : (mv_i > REL_MV);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_o <= 1'b0;
    end else if (sample_i) begin
      if (!trip_o && beyond_set) begin
        trip_o <= 1'b1;
      end else if (trip_o && inside_rel) begin
        trip_o <= 1'b0;
      end
    end
  end

endmodule : btg_hyst_cmp
`default_nettype wire

/* File: tb/btg_guard_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module btg_guard_properties
  import btg_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = 8,
  parameter int unsigned STEP_CYCLES   = 16
) (
  input wire logic             REF_CLK_I,        // clock
  input wire logic             RST_I,            // reset
  input wire logic             ADC_VALID_I,      // strobe
  input wire logic [1:0]       ADC_CHAN_I,       // channel
  input wire logic [ADC_W-1:0] ADC_MV_I,         // result
  input wire logic             DIE_HOT_I,        // die hot
  input wire logic             STRAP_ISRC_EN_O,  // strap source
  input wire logic             THERM_ISRC_EN_O,  // therm source
  input wire logic             READY_O,          // guarding
  input wire logic [2:0]       PROFILE_O,        // profile
  input wire logic             PROFILE_FAULT_O,  // strap fault
  input wire logic             CHG_INHIBIT_O,    // charge stop
  input wire logic             DSG_INHIBIT_O,    // discharge stop
  input wire logic             CUR_LIMIT_EN_O,   // limit on
  input wire logic [15:0]      CUR_LIMIT_MA_O,   // limit mA
  input wire logic             CV_DROP_EN_O,     // cv lowered
  input wire logic [2:0]       THROTTLE_LEVEL_O  // die level
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_quiet;
    !(READY_O && ADC_VALID_I && ADC_CHAN_I == CH_THERM);
  endsequence
  sequence s_therm;
    READY_O && ADC_VALID_I && ADC_CHAN_I == CH_THERM;
  endsequence
  property p_src_run;
    READY_O |-> !STRAP_ISRC_EN_O && THERM_ISRC_EN_O;
  endproperty
  a_src_run: assert property (p_src_run)
    else $error("sources wrong while guarding");
  property p_src_boot;
    !READY_O |-> STRAP_ISRC_EN_O && !THERM_ISRC_EN_O && CHG_INHIBIT_O && DSG_INHIBIT_O &&
                 !CUR_LIMIT_EN_O;
  endproperty
  a_src_boot: assert property (p_src_boot)
    else $error("sources wrong before guarding");
  property p_prof_held;
    READY_O [*3] |-> $stable(PROFILE_O);
  endproperty
  a_prof_held: assert property (p_prof_held)
    else $error("profile moved while guarding");
  property p_fault_map;
    READY_O [*2] |-> PROFILE_FAULT_O == (PROFILE_O == PROFILE_NONE);
  endproperty
  a_fault_map: assert property (p_fault_map)
    else $error("fault flag and profile disagree");
  property p_fault_inh;
    s_therm ##0 PROFILE_FAULT_O |-> ##2 (CHG_INHIBIT_O && DSG_INHIBIT_O);
  endproperty
  a_fault_inh: assert property (p_fault_inh)
    else $error("strap fault did not inhibit");
  property p_hold;
    s_quiet ##1 1'b1 |=> $stable({CHG_INHIBIT_O, DSG_INHIBIT_O, CUR_LIMIT_EN_O,
                                  CUR_LIMIT_MA_O, CV_DROP_EN_O});
  endproperty
  a_hold: assert property (p_hold)
    else $error("guard outputs moved without sample");
  property p_lim_chg;
    (CUR_LIMIT_EN_O || CV_DROP_EN_O) |-> !CHG_INHIBIT_O;
  endproperty
  a_lim_chg: assert property (p_lim_chg)
    else $error("limit with charge stopped");
  property p_lim_ma;
    CUR_LIMIT_EN_O == (CUR_LIMIT_MA_O != 16'h0000);
  endproperty
  a_lim_ma: assert property (p_lim_ma)
    else $error("limit flag and value disagree");
  property p_cv_prof;
    CV_DROP_EN_O |-> PROFILE_O == 3'h4;
  endproperty
  a_cv_prof: assert property (p_cv_prof)
    else $error("cv drop outside profile four");
  property p_thr_step;
    $changed(THROTTLE_LEVEL_O) |->
      (THROTTLE_LEVEL_O - $past(THROTTLE_LEVEL_O)) inside {3'h1, 3'h7};
  endproperty
  a_thr_step: assert property (p_thr_step)
    else $error("throttle jumped");
  property p_thr_gap;
    $changed(THROTTLE_LEVEL_O) |=> $stable(THROTTLE_LEVEL_O) [*8];
  endproperty
  a_thr_gap: assert property (p_thr_gap)
    else $error("throttle steps too close");
endmodule : btg_guard_properties
`default_nettype wire

/* File: tb/btg_adc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module btg_adc_model
  import btg_pkg::*;
(
  input  wire logic             clk_i,       // clock
  input  wire logic             strap_en_i,  // strap sources on
  input  wire logic             therm_en_i,  // therm source on
  input  wire logic             go_i,        // one extra conversion
  input  wire logic [1:0]       go_chan_i,   // its channel
  input  wire logic [ADC_W-1:0] prof_mv_i,   // profile strap
  input  wire logic [ADC_W-1:0] cap_mv_i,    // capacity strap
  input  wire logic [ADC_W-1:0] plim_mv_i,   // power strap
  input  wire logic [ADC_W-1:0] therm_mv_i,  // thermistor
  output logic                  valid_o,     // strobe
  output logic [1:0]            chan_o,      // channel
  output logic [ADC_W-1:0]      mv_o         // result
);
  logic [1:0] scan_q;
  // no source current means no voltage on the pin
  function automatic logic [ADC_W-1:0] level(input logic [1:0] ch);
    case (ch)
      CH_THERM:   level = therm_en_i ? therm_mv_i : 12'h000;
      CH_PROFILE: level = strap_en_i ? prof_mv_i : 12'h000;
      CH_CAP:     level = strap_en_i ? cap_mv_i : 12'h000;
      default:    level = strap_en_i ? plim_mv_i : 12'h000;
    endcase
  endfunction : level
  initial begin
    valid_o = 1'b0;
    chan_o = 2'h0;
    mv_o = 12'h000;
    scan_q = CH_PROFILE;
  end
  always @(posedge clk_i) begin
    valid_o <= go_i | strap_en_i;
    if (go_i) begin
      chan_o <= go_chan_i;
      mv_o <= level(go_chan_i);
    end else if (strap_en_i) begin
      chan_o <= scan_q;
      mv_o <= level(scan_q);
      scan_q <= (scan_q == CH_PLIM) ? CH_PROFILE : scan_q + 2'h1;
    end else begin
      mv_o <= ~mv_o;
    end
  end
endmodule : btg_adc_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
  import btg_pkg::*;
;
  localparam int unsigned STEP = 16;
  localparam logic [11:0] PV [10] = '{12'h0D7, 12'h0D8, 12'h17B, 12'h17C, 12'h258,
                                      12'h35C, 12'h4C4, 12'h6D6, 12'h9F6, 12'h9F7};
  localparam logic [2:0]  PE [10] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3,
                                      3'h4, 3'h5, 3'h6, 3'h6, 3'h0};
  logic clk, rst = 1'b1, hot = 1'b0, go = 1'b0, valid, strap_en, therm_en;
  logic ready, fault, chg, dsg, lim, cv;
  logic [1:0]  chan, go_chan = 2'h0;
  logic [2:0]  prof, thr;
  logic [11:0] mv, prof_mv = 12'h120, cap_mv = 12'h320, plim_mv = 12'h120, therm_mv = 12'h1CC;
  logic [15:0] lim_ma;
  int          error_cnt = 0;
  int          tests_run = 0;
  btg_guard #(.SETTLE_CYCLES(8), .STEP_CYCLES(STEP)) u_btg_guard (.REF_CLK_I(clk),
    .RST_I(rst), .ADC_VALID_I(valid), .ADC_CHAN_I(chan), .ADC_MV_I(mv), .DIE_HOT_I(hot),
    .STRAP_ISRC_EN_O(strap_en), .THERM_ISRC_EN_O(therm_en), .READY_O(ready),
    .PROFILE_O(prof), .PROFILE_FAULT_O(fault), .CHG_INHIBIT_O(chg), .DSG_INHIBIT_O(dsg),
    .CUR_LIMIT_EN_O(lim), .CUR_LIMIT_MA_O(lim_ma), .CV_DROP_EN_O(cv),
    .THROTTLE_LEVEL_O(thr));
  btg_adc_model u_btg_adc_model (.clk_i(clk), .strap_en_i(strap_en), .therm_en_i(therm_en),
    .go_i(go), .go_chan_i(go_chan), .prof_mv_i(prof_mv), .cap_mv_i(cap_mv),
    .plim_mv_i(plim_mv), .therm_mv_i(therm_mv), .valid_o(valid), .chan_o(chan), .mv_o(mv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test;
    $display("Comparisons %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic boot(input logic [11:0] p, input logic [11:0] c, input logic [11:0] w);
    int n;
    prof_mv = p;
    cap_mv = c;
    plim_mv = w;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chk("ready", 16'h0001, {15'h0000, n < 100});
    repeat (2) @(posedge clk);
    #1;
  endtask : boot
  task automatic send(input logic [1:0] ch, input logic [11:0] v);
    therm_mv = v;
    go_chan = ch;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : send
  task automatic tck(input logic [11:0] v, input logic c, input logic d, input logic l,
                     input logic [15:0] ma, input logic e);
    send(CH_THERM, v);
    chk("chg_inhibit", {15'h0000, c}, {15'h0000, chg});
    chk("dsg_inhibit", {15'h0000, d}, {15'h0000, dsg});
    chk("limit_en", {15'h0000, l}, {15'h0000, lim});
    chk("limit_ma", ma, lim_ma);
    chk("cv_drop", {15'h0000, e}, {15'h0000, cv});
  endtask : tck
  task automatic row(input logic [11:0] p, input logic [11:0] c, input logic [11:0] v,
                     input logic cs, input logic ds, input logic l, input logic [15:0] ma,
                     input logic e);
    boot(p, c, 12'h120);
    tck(v, cs, ds, l, ma, e);
  endtask : row
  task automatic t_profile;
    for (int i = 0; i < 10; i++) begin
      boot(PV[i], 12'h320, 12'h120);
      chk("profile", {13'h0000, PE[i]}, {13'h0000, prof});
      chk("profile_fault", {15'h0000, PE[i] == 3'h0}, {15'h0000, fault});
      tck(12'h1CC, PE[i] == 3'h0, PE[i] == 3'h0, 1'b0, 16'h0000, 1'b0);
    end
  endtask : t_profile
  task automatic t_rows;
    row(12'h120, 12'h320, 12'h258, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    row(12'h2D8, 12'h320, 12'h17C, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    row(12'h120, 12'h320, 12'h578, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    row(12'h5A0, 12'h320, 12'h0E6, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    row(12'h1F0, 12'h320, 12'h1FE, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    row(12'h1F0, 12'h320, 12'h19F, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    row(12'h1F0, 12'h320, 12'h366, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    row(12'h2D8, 12'h320, 12'h10E, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    row(12'h410, 12'h320, 12'h384, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    row(12'h870, 12'h320, 12'h10E, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
    row(12'h410, 12'h320, 12'h2BC, 1'b0, 1'b0, 1'b1, 16'h07D0, 1'b0);
    row(12'h410, 12'h320, 12'h181, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
    row(12'h5A0, 12'h320, 12'h1E0, 1'b0, 1'b0, 1'b1, 16'h03E8, 1'b0);
    row(12'h870, 12'h320, 12'h181, 1'b0, 1'b0, 1'b1, 16'h07D0, 1'b0);
    row(12'h410, 12'hA8C, 12'h2BC, 1'b0, 1'b0, 1'b1, 16'h1770, 1'b0);
    row(12'h410, 12'h0A0, 12'h2BC, 1'b0, 1'b0, 1'b1, 16'h0190, 1'b0);
  endtask : t_rows
  task automatic t_hyst;
    boot(12'h120, 12'h320, 12'h120);
    tck(12'h258, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    tck(12'h208, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    tck(12'h1CC, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
    tck(12'h17C, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    tck(12'h1A4, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
    tck(12'h1CC, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
    prof_mv = 12'h870;
    send(CH_PROFILE, 12'h1CC);
    chk("profile_held", 16'h0001, {13'h0000, prof});
    chk("fault_held", 16'h0000, {15'h0000, fault});
  endtask : t_hyst
  task automatic t_thr(input logic [11:0] w, input logic [2:0] e);
    boot(12'h120, 12'h320, w);
    hot = 1'b1;
    repeat ((e + 2) * STEP + 8) @(posedge clk);
    #1 chk("throttle_hot", {13'h0000, e}, {13'h0000, thr});
    hot = 1'b0;
    repeat ((e + 1) * STEP + 8) @(posedge clk);
    #1 chk("throttle_cool", 16'h0000, {13'h0000, thr});
  endtask : t_thr
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    t_profile();
    t_rows();
    t_hyst();
    t_thr(12'h120, 3'h1);
    t_thr(12'h2D8, 3'h3);
    t_thr(12'h00A, 3'h7);
    finish_test();
  end
endmodule : tb
bind btg_guard btg_guard_properties #(.SETTLE_CYCLES(SETTLE_CYCLES), .STEP_CYCLES(STEP_CYCLES))
  u_btg_guard_properties (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADC_VALID_I(ADC_VALID_I),
  .ADC_CHAN_I(ADC_CHAN_I), .ADC_MV_I(ADC_MV_I), .DIE_HOT_I(DIE_HOT_I),
  .STRAP_ISRC_EN_O(STRAP_ISRC_EN_O), .THERM_ISRC_EN_O(THERM_ISRC_EN_O), .READY_O(READY_O),
  .PROFILE_O(PROFILE_O), .PROFILE_FAULT_O(PROFILE_FAULT_O), .CHG_INHIBIT_O(CHG_INHIBIT_O),
  .DSG_INHIBIT_O(DSG_INHIBIT_O), .CUR_LIMIT_EN_O(CUR_LIMIT_EN_O),
  .CUR_LIMIT_MA_O(CUR_LIMIT_MA_O), .CV_DROP_EN_O(CV_DROP_EN_O),
  .THROTTLE_LEVEL_O(THROTTLE_LEVEL_O));
`default_nettype wire
